// file: logic/counter_pkg.sv
// Shared constants and types for the presettable up/down binary counter.
// Assumes a single 40 MHz clock domain and a 32-bit AXI4-Lite register bus.
package counter_pkg;

  // Counter geometry.
  localparam int         COUNT_WIDTH = 4;

  // Byte offsets of the register words.
  localparam logic [11:0] OFFSET_CONTROL = 12'h000;
  localparam logic [11:0] OFFSET_PRESET  = 12'h004;
  localparam logic [11:0] OFFSET_STATUS  = 12'h008;

  // Field positions inside the register words.
  localparam int         CTRL_COUNT_UP_BIT    = 0;
  localparam int         CTRL_PRESET_LOAD_BIT = 1;
  localparam int         CTRL_CLEAR_BIT       = 2;
  localparam int         CTRL_FIELD_WIDTH     = 3;
  localparam int         PRESET_FIELD_WIDTH   = 4;
  localparam int         STATUS_COUNT_LSB     = 0;
  localparam int         STATUS_CARRY_BIT     = 4;
  localparam int         STATUS_CASCADE_BIT   = 5;
  localparam int         STATUS_FIELD_WIDTH   = 6;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Control bits written by software.
  typedef struct packed {
    logic clear;
    logic preset_load;
    logic count_up;
  } ctrl_t;

  // Parallel preset value, least significant bit last.
  typedef struct packed {
    logic preset_value_bit3;
    logic preset_value_bit2;
    logic preset_value_bit1;
    logic preset_value_bit0;
  } preset_t;

  // Read-only view of the counter's own state.
  typedef struct packed {
    logic                   cascade_in_n;
    logic                   carry_out_n;
    logic [COUNT_WIDTH-1:0] count;
  } status_t;

  // Reset values.
  localparam ctrl_t   CTRL_RESET   = '{clear: 1'b0, preset_load: 1'b0,
                                       count_up: 1'b1};
  localparam preset_t PRESET_RESET = preset_t'(4'h0);

endpackage : counter_pkg

// file: logic/toggle_stage.sv
// One bit of the counter, built as a toggle flip-flop with parallel load.
// Assumes its toggle input is already gated by every clock inhibit.
`timescale 1ns/10ps
module toggle_stage (
  input  wire logic clock,        // System clock.
  input  wire logic sys_rst,      // Asynchronous reset, active high.
  input  wire logic clear,        // Forces the bit low.
  input  wire logic load,         // Takes the parallel input.
  input  wire logic parallel_in,  // Preset value for this bit.
  input  wire logic toggle,       // Inverts the bit on this edge.
  output logic      q             // Stored bit.
);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      q <= 1'b0;
    end else if (clear) begin
      q <= 1'b0;
    end else if (load) begin
      q <= parallel_in;
    end else if (toggle) begin
      q <= ~q;
    end
  end

endmodule : toggle_stage

// file: logic/count_step_logic.sv
// Toggle enables and terminal count detection for a binary up/down counter.
// Assumes the count comes from flip-flops on the same clock.
`timescale 1ns/10ps
module count_step_logic #(
  parameter int WIDTH = counter_pkg::COUNT_WIDTH  // Number of count bits.
) (
  input  wire logic [WIDTH-1:0] count,        // Present count.
  input  wire logic             count_up,     // High counts up.
  input  wire logic             step_enable,  // Clock not inhibited.
  output logic      [WIDTH-1:0] toggle,       // Per-bit toggle enables.
  output logic                  terminal      // All ones up, all zeros down.
);

  if (WIDTH < 1) begin : g_bad_width
    $error("count_step_logic needs at least one bit");
  end

  logic [WIDTH:0] up_run;
  logic [WIDTH:0] down_run;

  assign up_run[0]   = 1'b1;
  assign down_run[0] = 1'b1;

  // A bit toggles when every lower bit is one (up) or zero (down), which
  // also makes the count wrap modulo two to the width.
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    assign up_run[i+1]   = up_run[i] & count[i];
    assign down_run[i+1] = down_run[i] & ~count[i];
    assign toggle[i]     = step_enable &
                           (count_up ? up_run[i] : down_run[i]);
  end

  assign terminal = count_up ? up_run[WIDTH] : down_run[WIDTH];

endmodule : count_step_logic

// file: logic/presettable_updown_binary_counter.sv
// Four-bit presettable up/down binary counter with cascade carry and an
// AXI4-Lite register slave for its control, preset and status words.
// Assumes the cascade input comes from a stage on the same clock, so it is
// used without synchronisation, and that the bus master is on that clock.
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
module presettable_updown_binary_counter #(
  parameter int ADDR_WIDTH = 12  // AXI address width.
) (
  input  wire logic                  clock,          // 40 MHz clock.
  input  wire logic                  sys_rst,        // Async reset, high.
  // Cascade link to neighbouring stages.
  input  wire logic                  cascade_in_n,   // Carry in, low.
  output logic                       carry_out_n,    // Carry out, low.
  output logic                       count_bit0,     // Count, LSB.
  output logic                       count_bit1,     // Count bit 1.
  output logic                       count_bit2,     // Count bit 2.
  output logic                       count_bit3,     // Count, MSB.
  // AXI4-Lite slave.
  input  wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,   // Write address.
  input  wire logic [2:0]            s_axi_awprot,   // Unused.
  input  wire logic                  s_axi_awvalid,  // Write addr valid.
  output logic                       s_axi_awready,  // Write addr ready.
  input  wire logic [31:0]           s_axi_wdata,    // Write data.
  input  wire logic [3:0]            s_axi_wstrb,    // Byte enables.
  input  wire logic                  s_axi_wvalid,   // Write data valid.
  output logic                       s_axi_wready,   // Write data ready.
  output logic [1:0]                 s_axi_bresp,    // Write response.
  output logic                       s_axi_bvalid,   // Response valid.
  input  wire logic                  s_axi_bready,   // Response ready.
  input  wire logic [ADDR_WIDTH-1:0] s_axi_araddr,   // Read address.
  input  wire logic [2:0]            s_axi_arprot,   // Unused.
  input  wire logic                  s_axi_arvalid,  // Read addr valid.
  output logic                       s_axi_arready,  // Read addr ready.
  output logic [31:0]                s_axi_rdata,    // Read data.
  output logic [1:0]                 s_axi_rresp,    // Read response.
  output logic                       s_axi_rvalid,   // Read data valid.
  input  wire logic                  s_axi_rready    // Read data ready.
);

  localparam int W = counter_pkg::COUNT_WIDTH;

  if (ADDR_WIDTH < 4 || ADDR_WIDTH > 12) begin : g_bad_addr
    $error("ADDR_WIDTH must lie between 4 and 12");
  end

  // ---------------------------------------------------------------------
  // Register state.
  // ---------------------------------------------------------------------
  counter_pkg::ctrl_t   ctrl;
  counter_pkg::preset_t preset;
  logic [W-1:0]         count;
  logic [W-1:0]         toggle;
  logic                 terminal;
  logic                 step_enable;

  // ---------------------------------------------------------------------
  // Write channel bookkeeping.
  // ---------------------------------------------------------------------
  logic                  aw_held;
  logic [ADDR_WIDTH-1:0] aw_addr;
  logic                  w_held;
  logic [31:0]           w_data;
  logic [3:0]            w_strb;

  wire aw_take        = s_axi_awvalid & s_axi_awready;
  wire w_take         = s_axi_wvalid & s_axi_wready;
  wire write_go       = aw_held & w_held & ~s_axi_bvalid;
  wire next_aw_held   = write_go ? 1'b0 : (aw_held | aw_take);
  wire next_w_held    = write_go ? 1'b0 : (w_held | w_take);
  wire next_bvalid    = write_go | (s_axi_bvalid & ~s_axi_bready);
  wire next_awready   = ~next_aw_held & ~next_bvalid;
  wire next_wready    = ~next_w_held & ~next_bvalid;

  // Addresses decode on the whole word; the two low bits are ignored.
  wire [11:0] wr_word = 12'(aw_addr) & 12'hFFC;
  wire        wr_ctrl   = (wr_word == counter_pkg::OFFSET_CONTROL);
  wire        wr_preset = (wr_word == counter_pkg::OFFSET_PRESET);
  wire        wr_status = (wr_word == counter_pkg::OFFSET_STATUS);
  wire        wr_mapped = wr_ctrl | wr_preset | wr_status;
  wire        wr_lane0  = w_strb[0];

  wire [1:0] next_bresp = wr_mapped ? counter_pkg::RESP_OKAY
                                    : counter_pkg::RESP_SLVERR;

  wire counter_pkg::ctrl_t next_ctrl =
    (write_go & wr_ctrl & wr_lane0)
      ? counter_pkg::ctrl_t'(w_data[counter_pkg::CTRL_FIELD_WIDTH-1:0])
      : ctrl;
  wire counter_pkg::preset_t next_preset =
    (write_go & wr_preset & wr_lane0)
      ? counter_pkg::preset_t'(w_data[counter_pkg::PRESET_FIELD_WIDTH-1:0])
      : preset;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      aw_addr <= '0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= counter_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      if (write_go) begin
        s_axi_bresp <= next_bresp;
      end
    end
  end

  // Writes to the status word are accepted and have no effect.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl   <= counter_pkg::CTRL_RESET;
      preset <= counter_pkg::PRESET_RESET;
    end else begin
      ctrl   <= next_ctrl;
      preset <= next_preset;
    end
  end

  // ---------------------------------------------------------------------
  // Read channel.
  // ---------------------------------------------------------------------
  counter_pkg::status_t status;

  assign status.cascade_in_n = cascade_in_n;
  assign status.carry_out_n  = carry_out_n;
  assign status.count        = count;

  wire ar_take      = s_axi_arvalid & s_axi_arready;
  wire next_rvalid  = ar_take | (s_axi_rvalid & ~s_axi_rready);
  wire next_arready = ~next_rvalid;

  wire [11:0] rd_word   = 12'(s_axi_araddr) & 12'hFFC;
  wire        rd_ctrl   = (rd_word == counter_pkg::OFFSET_CONTROL);
  wire        rd_preset = (rd_word == counter_pkg::OFFSET_PRESET);
  wire        rd_status = (rd_word == counter_pkg::OFFSET_STATUS);
  wire        rd_mapped = rd_ctrl | rd_preset | rd_status;

  wire [31:0] ctrl_word   = {29'h0000_0000, ctrl};
  wire [31:0] preset_word = {28'h000_0000, preset};
  wire [31:0] status_word = {26'h000_0000, status};

  wire [31:0] next_rdata = rd_ctrl   ? ctrl_word   :
                           rd_preset ? preset_word :
                           rd_status ? status_word : 32'h0000_0000;
  wire [1:0]  next_rresp = rd_mapped ? counter_pkg::RESP_OKAY
                                     : counter_pkg::RESP_SLVERR;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= counter_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      if (ar_take) begin
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= next_rresp;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Counter core.
  // ---------------------------------------------------------------------
  // Load and clear act on each clock while held rather than truly without
  // the clock: an asynchronous load from a register would need a data
  // dependent reset, which this library does not allow.
  assign step_enable = ~cascade_in_n & ~ctrl.preset_load
                     & ~ctrl.clear;

  count_step_logic #(
    .WIDTH       (W)
  ) u_step (
    .count       (count),
    .count_up    (ctrl.count_up),
    .step_enable (step_enable),
    .toggle      (toggle),
    .terminal    (terminal)
  );

  wire [W-1:0] preset_bits = preset;

  for (genvar i = 0; i < W; i++) begin : g_stage
    toggle_stage u_bit (
      .clock       (clock),
      .sys_rst     (sys_rst),
      .clear       (ctrl.clear),
      .load        (ctrl.preset_load),
      .parallel_in (preset_bits[i]),
      .toggle      (toggle[i]),
      .q           (count[i])
    );
  end

  // The carry is decoded from the count flip-flops and the carry input
  // without a further register, so that a chained stage steps on the very
  // edge at which this stage leaves terminal count.
  assign carry_out_n = ~(terminal & ~cascade_in_n);

  assign count_bit0 = count[0];
  assign count_bit1 = count[1];
  assign count_bit2 = count[2];
  assign count_bit3 = count[3];

endmodule : presettable_updown_binary_counter

// file: testbench/counter_properties.sv
// Concurrent checks on the counter's ports, bound to the counter top.
// Assumes one clock domain and the register map of the counter package.
`timescale 1ns/10ps
module counter_properties #(
  parameter int ADDR_WIDTH = 12  // AXI address width.
) (
  input wire logic                  clock,          // Clock.
  input wire logic                  sys_rst,        // Reset, high.
  input wire logic                  cascade_in_n,   // Carry in.
  input wire logic                  carry_out_n,    // Carry out.
  input wire logic                  count_bit0,     // Count LSB.
  input wire logic                  count_bit1,     // Count bit 1.
  input wire logic                  count_bit2,     // Count bit 2.
  input wire logic                  count_bit3,     // Count MSB.
  input wire logic                  s_axi_awvalid,  // Write addr valid.
  input wire logic                  s_axi_awready,  // Write addr ready.
  input wire logic                  s_axi_wvalid,   // Write data valid.
  input wire logic                  s_axi_wready,   // Write data ready.
  input wire logic                  s_axi_bvalid,   // Response valid.
  input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,   // Read address.
  input wire logic                  s_axi_arvalid,  // Read addr valid.
  input wire logic                  s_axi_arready,  // Read addr ready.
  input wire logic [31:0]           s_axi_rdata,    // Read data.
  input wire logic                  s_axi_rvalid    // Read data valid.
);
  logic [3:0] cnt;
  logic [1:0] bv_hist;
  logic       quiet;

  assign cnt = {count_bit3, count_bit2, count_bit1, count_bit0};
  // A register write changes what the next edges do, so step checks only
  // hold once no write has landed in the last three edges.
  assign quiet = !s_axi_bvalid && (bv_hist == 2'h0);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      bv_hist <= 2'h0;
    end else begin
      bv_hist <= {bv_hist[0], s_axi_bvalid};
    end
  end

  default clocking dc @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_answer;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence

  property p_hold;
    cascade_in_n && !s_axi_bvalid |=> $stable(cnt);
  endproperty
  a_hold: assert property (p_hold)
    else $error("count moved while carry in was high");

  property p_carry_gate;
    !carry_out_n |-> !cascade_in_n && (cnt == 4'h0 || cnt == 4'hF);
  endproperty
  a_carry_gate: assert property (p_carry_gate)
    else $error("carry out low without terminal count");

  property p_carry_term;
    !cascade_in_n && cnt != 4'h0 && cnt != 4'hF |-> carry_out_n;
  endproperty
  a_carry_term: assert property (p_carry_term)
    else $error("carry out low at a mid count");

  property p_keep_up;
    quiet && !cascade_in_n && cnt == $past(cnt) + 4'h1
      |=> cnt == $past(cnt) + 4'h1;
  endproperty
  a_keep_up: assert property (p_keep_up)
    else $error("up count did not step by one");

  property p_keep_down;
    quiet && !cascade_in_n && cnt == $past(cnt) - 4'h1
      |=> cnt == $past(cnt) - 4'h1;
  endproperty
  a_keep_down: assert property (p_keep_down)
    else $error("down count did not step by one");

  property p_status;
    s_axi_arvalid && s_axi_arready
      && s_axi_araddr == counter_pkg::OFFSET_STATUS
      |=> s_axi_rdata == {26'h0, $past(cascade_in_n), $past(carry_out_n),
                          $past(cnt)};
  endproperty
  a_status: assert property (p_status)
    else $error("status word does not match the pins");

  property p_wr_lat;
    s_wr_take |=> s_wr_answer;
  endproperty
  a_wr_lat: assert property (p_wr_lat)
    else $error("write response not two edges after take");

  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("read data not one edge after take");
endmodule : counter_properties

// file: testbench/cascade_neighbour.sv
// Behavioural neighbour stage that feeds the counter's carry input.
// Assumes the bench drives mode on the shared clock.
`timescale 1ns/10ps
module cascade_neighbour (
  input  wire logic       clock,          // Shared clock.
  input  wire logic       sys_rst,        // Reset, high.
  input  wire logic [1:0] mode,           // 0 hold, 1 enable, 2 chained.
  output logic            cascade_out_n   // To the counter's carry in.
);
  logic [3:0] digit;

  // Chained mode is a lower stage counting down on the same clock.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      digit <= 4'h0;
    end else if (mode == 2'h2) begin
      digit <= digit - 4'h1;
    end else begin
      digit <= 4'h0;
    end
  end

  assign cascade_out_n = (mode == 2'h1) ? 1'b0 :
                         (mode == 2'h2) ? (digit != 4'h0) : 1'b1;
endmodule : cascade_neighbour

// file: testbench/presettable_updown_binary_counter_bench.sv
// Self-checking bench for the counter: table of preset and step runs,
// then carry, clear, bus refusal and chained cases. One clock at 40 MHz.
`timescale 1ns/10ps
module presettable_updown_binary_counter_bench;
  typedef struct {
    logic [3:0] pre;
    logic       up;
    int         n;
    logic [3:0] want;
  } row_t;

  logic        clock, sys_rst, cascade_in_n, carry_out_n;
  wire  [3:0]  count;
  logic [1:0]  mode, bresp, rresp, rs;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_data;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic [3:0]  wstrb;
  logic        arvalid, arready, rvalid, rready;
  int          error_cnt, checks, cycles;
  row_t rows [6] = '{'{4'h3, 1'b0, 3, 4'h0}, '{4'h3, 1'b0, 4, 4'hF},
                     '{4'hE, 1'b1, 1, 4'hF}, '{4'hE, 1'b1, 2, 4'h0},
                     '{4'h0, 1'b1, 5, 4'h5}, '{4'h9, 1'b0, 16, 4'h9}};

  presettable_updown_binary_counter uut (
    .clock(clock), .sys_rst(sys_rst), .cascade_in_n(cascade_in_n),
    .carry_out_n(carry_out_n), .count_bit0(count[0]),
    .count_bit1(count[1]), .count_bit2(count[2]), .count_bit3(count[3]),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  cascade_neighbour nb (.clock(clock), .sys_rst(sys_rst), .mode(mode),
                        .cascade_out_n(cascade_in_n));

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(logic [11:0] a, logic [31:0] d, logic [1:0] er);
    @(posedge clock);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask : wr

  task automatic rd(logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clock);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask : rd

  // Holds the neighbour in mode m for exactly n edges, then lets it settle.
  task automatic run(logic [1:0] m, int n);
    @(posedge clock);
    mode <= m;
    repeat (n) @(posedge clock);
    mode <= 2'h0;
    repeat (2) @(posedge clock);
  endtask : run

  function automatic logic [31:0] ctl(logic clr, logic ld, logic up);
    return {29'h0, clr, ld, up};
  endfunction : ctl

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      summarize();
    end
  end

  initial begin
    {mode, awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    sys_rst = 1'b1;
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    chk("count", 4'h0, count);
    chk("carry", 1'b1, carry_out_n);
    rd(counter_pkg::OFFSET_CONTROL, rd_data, rs);
    chk("control", 32'h1, rd_data);
    rd(counter_pkg::OFFSET_PRESET, rd_data, rs);
    chk("preset", 32'h0, rd_data);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(counter_pkg::OFFSET_PRESET, {28'h0, rows[i].pre}, 2'h0);
      wr(counter_pkg::OFFSET_CONTROL, ctl(0, 1, rows[i].up), 2'h0);
      repeat (2) @(posedge clock);
      chk("loaded", rows[i].pre, count);
      wr(counter_pkg::OFFSET_CONTROL, ctl(0, 0, rows[i].up), 2'h0);
      run(2'h1, rows[i].n);
      chk("stepped", rows[i].want, count);
    end
    $display("test table done");
    wr(counter_pkg::OFFSET_PRESET, 32'hF, 2'h0);
    wr(counter_pkg::OFFSET_CONTROL, ctl(0, 1, 1), 2'h0);
    repeat (2) @(posedge clock);
    wr(counter_pkg::OFFSET_CONTROL, ctl(0, 0, 1), 2'h0);
    chk("carry held", 1'b1, carry_out_n);
    @(posedge clock) mode <= 2'h1;
    @(negedge clock) chk("carry up", 1'b0, carry_out_n);
    @(posedge clock) mode <= 2'h0;
    @(negedge clock) chk("carry after", 1'b1, carry_out_n);
    wr(counter_pkg::OFFSET_CONTROL, ctl(0, 0, 0), 2'h0);
    @(posedge clock) mode <= 2'h1;
    @(negedge clock) chk("carry down", 1'b0, carry_out_n);
    @(posedge clock) mode <= 2'h0;
    @(negedge clock) chk("count wrap", 4'hF, count);
    $display("test carry done");
    wr(counter_pkg::OFFSET_CONTROL, ctl(1, 0, 1), 2'h0);
    run(2'h1, 5);
    chk("cleared", 4'h0, count);
    wr(counter_pkg::OFFSET_CONTROL, ctl(0, 0, 1), 2'h0);
    $display("test clear done");
    wr(12'h00C, 32'h7, 2'h2);
    rd(12'h00C, rd_data, rs);
    chk("unmapped", 32'h0, rd_data);
    chk("unmapped resp", 2'h2, rs);
    wr(counter_pkg::OFFSET_STATUS, 32'h3F, 2'h0);
    rd(counter_pkg::OFFSET_STATUS, rd_data, rs);
    chk("status", 32'h30, rd_data);
    // Byte lane zero off: the write is answered but must not land.
    wstrb <= 4'h0;
    wr(counter_pkg::OFFSET_PRESET, 32'hA, 2'h0);
    wstrb <= 4'hF;
    rd(counter_pkg::OFFSET_PRESET, rd_data, rs);
    chk("masked", 32'hF, rd_data);
    $display("test bus done");
    run(2'h2, 33);
    chk("chained", 4'h3, count);
    $display("test chain done");
    // Divider use: a nonzero ratio, counted down to terminal count.
    wr(counter_pkg::OFFSET_PRESET, 32'h5, 2'h0);
    wr(counter_pkg::OFFSET_CONTROL, ctl(0, 1, 0), 2'h0);
    repeat (2) @(posedge clock);
    wr(counter_pkg::OFFSET_CONTROL, ctl(0, 0, 0), 2'h0);
    run(2'h1, 5);
    chk("divided", 4'h0, count);
    @(posedge clock) mode <= 2'h1;
    @(negedge clock) chk("divide carry", 1'b0, carry_out_n);
    @(posedge clock) mode <= 2'h0;
    $display("test divider done");
    @(posedge clock) sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    chk("count again", 4'h0, count);
    rd(counter_pkg::OFFSET_CONTROL, rd_data, rs);
    chk("control again", 32'h1, rd_data);
    $display("test reset again done");
    summarize();
  end
endmodule : presettable_updown_binary_counter_bench

bind presettable_updown_binary_counter counter_properties #(
  .ADDR_WIDTH(ADDR_WIDTH)
) props (
  .clock(clock), .sys_rst(sys_rst), .cascade_in_n(cascade_in_n),
  .carry_out_n(carry_out_n), .count_bit0(count_bit0),
  .count_bit1(count_bit1), .count_bit2(count_bit2),
  .count_bit3(count_bit3), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid));
